// File: src/scc_pkg.sv
// shared constants, types and register map of the conversion control block
package scc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RESULT_W = 18;
  // longest conversion time, rounded down to whole cycles
  localparam int unsigned CONV_TIME_NS = 310;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  // least time the start input must stand high after nap, rounded up
  localparam int unsigned NAP_WAKE_NS = 200;
  localparam int unsigned NAP_WAKE_CYCLES = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  // bus-width select codes
  localparam logic [1:0] BUS_MODE_P18 = 2'h0;
  localparam logic [1:0] BUS_MODE_P16 = 2'h1;
  localparam logic [1:0] BUS_MODE_P8 = 2'h2;
  localparam logic [1:0] BUS_MODE_SER = 2'h3;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_LEVEL = 8'h0c;
  // control register fields
  localparam int unsigned CTRL_RESET_BIT = 0;
  localparam int unsigned CTRL_FIFO_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
  // status register fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_NAP_BIT = 1;
  localparam int unsigned ST_SHDN_BIT = 2;
  localparam int unsigned ST_EMPTY_BIT = 3;
  localparam int unsigned ST_FULL_BIT = 4;
  localparam int unsigned ST_HELD_BIT = 5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_NAP = 4'h4,
    ST_SHDN = 4'h8
  } scc_state_t;
endpackage

// File: src/scc_stream_if.sv
// valid/ready word stream between the controller and its result fifo
`timescale 1ns/100ps
interface scc_stream_if #(parameter int unsigned WIDTH = 18);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: src/scc_fifo.sv
// result fifo with parameter width and depth, flip-flop storage
`timescale 1ns/100ps
module scc_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  scc_stream_if.snk wr,
  scc_stream_if.src rd,
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign wr.ready = (cnt_ff != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_ff != '0);
  assign rd.data = mem_ff[rptr_ff];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;
  assign level = cnt_ff;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wptr_ff] <= wr.data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else if (flush) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// File: src/scc_core.sv
// conversion, nap and shutdown control with parallel bus and ahb-lite registers
`timescale 1ns/100ps
module scc_core #(
  parameter int unsigned CONV_CYC = scc_pkg::CONV_CYCLES,
  parameter int unsigned WAKE_CYC = scc_pkg::NAP_WAKE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic conversion_start_n,
  input wire logic shutdown_request,
  input wire logic reset_pin,
  input wire logic chip_select_n,
  input wire logic [1:0] bus_mode,
  input wire logic [scc_pkg::RESULT_W-1:0] sample_in,
  output logic busy,
  output logic nap_active,
  output logic powered_down,
  output logic [scc_pkg::RESULT_W-1:0] data_out,
  output logic [scc_pkg::RESULT_W-1:0] data_oe,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  localparam int unsigned RW = scc_pkg::RESULT_W;

  scc_pkg::scc_state_t state_ff;
  scc_pkg::scc_state_t nxt_state;
  logic start_d_ff;
  logic [scc_pkg::CNT_W-1:0] conv_cnt_ff;
  logic [scc_pkg::CNT_W-1:0] high_cnt_ff;
  logic [RW-1:0] result_ff;
  logic held_ff;
  logic busy_ff;
  logic nap_ff;
  logic shdn_ff;
  logic [RW-1:0] dout_ff;
  logic [RW-1:0] doe_ff;
  logic [1:0] ctrl_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic [4:0] level;
  logic start_fall;
  logic conv_done;
  logic in_reset;
  logic woken;
  logic addr_ok;
  logic fifo_pop;
  logic take;
  logic hresp_ff;

  // ***********************************************************
  // decode helpers
  // ***********************************************************
  // a whole-word single transfer is taken in its address phase
  function automatic logic ahb_take(input logic sel, input logic [1:0] trans,
                                    input logic [2:0] size);
    return sel && (trans == scc_pkg::HTRANS_NONSEQ) && (size == scc_pkg::HSIZE_WORD);
  endfunction

  // offsets that select one of the four registers
  function automatic logic reg_known(input logic [7:0] addr);
    return (addr == scc_pkg::REG_CTRL) || (addr == scc_pkg::REG_STATUS) ||
           (addr == scc_pkg::REG_RESULT) || (addr == scc_pkg::REG_LEVEL);
  endfunction

  // ***********************************************************
  // result fifo
  // ***********************************************************
  scc_stream_if #(.WIDTH(RW)) push_if ();
  scc_stream_if #(.WIDTH(RW)) pop_if ();

  scc_fifo #(.WIDTH(RW), .DEPTH(scc_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(in_reset),
    .wr(push_if),
    .rd(pop_if),
    .level(level)
  );

  // ***********************************************************
  // conversion control
  // ***********************************************************
  assign in_reset = reset_pin | ctrl_ff[scc_pkg::CTRL_RESET_BIT];
  assign start_fall = start_d_ff & ~conversion_start_n;
  assign conv_done = (state_ff == scc_pkg::ST_CONV) &&
                     (conv_cnt_ff == scc_pkg::CNT_W'(CONV_CYC - 1));
  assign woken = (high_cnt_ff >= scc_pkg::CNT_W'(WAKE_CYC));
  // a start edge that finds the fifo full is ignored, not held, when the fifo is enabled
  assign push_if.valid = conv_done & ctrl_ff[scc_pkg::CTRL_FIFO_EN_BIT];
  assign push_if.data = sample_in;

  // ***********************************************************
  // start edge and wake counter
  // ***********************************************************

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_d_ff <= 1'b1;
    end else begin
      start_d_ff <= conversion_start_n;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      high_cnt_ff <= '0;
    end else if (conversion_start_n) begin
      if (!woken) begin
        high_cnt_ff <= high_cnt_ff + 1'b1;
      end
    end else begin
      high_cnt_ff <= '0;
    end
  end

  // ***********************************************************
  // state machine
  // ***********************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      scc_pkg::ST_IDLE: begin
        if (shutdown_request) begin
          nxt_state = scc_pkg::ST_SHDN;
        end else if (start_fall && (push_if.ready || !ctrl_ff[scc_pkg::CTRL_FIFO_EN_BIT])) begin
          nxt_state = scc_pkg::ST_CONV;
        end else if (!conversion_start_n && !start_d_ff) begin
          nxt_state = scc_pkg::ST_NAP;
        end
      end
      scc_pkg::ST_CONV: begin
        if (conv_done) begin
          nxt_state = shutdown_request ? scc_pkg::ST_SHDN : scc_pkg::ST_IDLE;
        end
      end
      scc_pkg::ST_NAP: begin
        if (shutdown_request) begin
          nxt_state = scc_pkg::ST_SHDN;
        end else if (conversion_start_n && woken) begin
          nxt_state = scc_pkg::ST_IDLE;
        end
      end
      scc_pkg::ST_SHDN: begin
        if (!shutdown_request) begin
          nxt_state = scc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = scc_pkg::ST_IDLE;
      end
    endcase
    if (in_reset) begin
      nxt_state = scc_pkg::ST_IDLE;
    end
  end

  // resetn models the power-on reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= scc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ***********************************************************
  // conversion counter
  // ***********************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_cnt_ff <= '0;
    end else if (state_ff == scc_pkg::ST_CONV && !conv_done && !in_reset) begin
      conv_cnt_ff <= conv_cnt_ff + 1'b1;
    end else begin
      conv_cnt_ff <= '0;
    end
  end

  // ***********************************************************
  // result capture and status
  // ***********************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_ff <= '0;
      held_ff <= 1'b0;
    end else if (in_reset) begin
      held_ff <= 1'b0;
    end else if (conv_done) begin
      result_ff <= sample_in;
      held_ff <= shutdown_request;
    end else if (state_ff != scc_pkg::ST_SHDN) begin
      held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      nap_ff <= 1'b0;
      shdn_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state == scc_pkg::ST_CONV);
      nap_ff <= (nxt_state == scc_pkg::ST_NAP);
      shdn_ff <= (nxt_state == scc_pkg::ST_SHDN);
    end
  end

  // ***********************************************************
  // parallel data bus
  // ***********************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dout_ff <= '0;
      doe_ff <= '0;
    end else begin
      if (conv_done) begin
        dout_ff <= sample_in;
      end else if (bus_mode == scc_pkg::BUS_MODE_P18) begin
        dout_ff <= result_ff;
      end
      if (!chip_select_n && !in_reset && bus_mode == scc_pkg::BUS_MODE_P18) begin
        doe_ff <= '1;
      end else begin
        doe_ff <= '0;
      end
    end
  end

  assign busy = busy_ff;
  assign nap_active = nap_ff;
  assign powered_down = shdn_ff;
  assign data_out = dout_ff;
  assign data_oe = doe_ff;

  // ***********************************************************
  // ahb-lite register slave
  // ***********************************************************
  assign take = hready & ahb_take(hsel, htrans, hsize);
  assign addr_ok = reg_known(haddr);
  assign fifo_pop = rd_pend_ff && (addr_ff == scc_pkg::REG_RESULT) && pop_if.valid &&
                    ctrl_ff[scc_pkg::CTRL_FIFO_EN_BIT];
  assign pop_if.ready = fifo_pop;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= '0;
    end else if (hready) begin
      wr_pend_ff <= take && hwrite && addr_ok;
      rd_pend_ff <= take && !hwrite;
      addr_ff <= haddr;
    end else begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end
  end

  // ***********************************************************
  // control register
  // ***********************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= scc_pkg::CTRL_RESET_VAL;
    end else if (wr_pend_ff && addr_ff == scc_pkg::REG_CTRL) begin
      ctrl_ff <= hwdata[1:0];
    end
  end

  // ***********************************************************
  // read data and response
  // ***********************************************************
  // read data is registered at the address phase and stands in the data phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata_ff <= '0;
    end else if (take && !hwrite) begin
      if (haddr == scc_pkg::REG_CTRL) begin
        hrdata_ff <= {30'h0, ctrl_ff};
      end else if (haddr == scc_pkg::REG_STATUS) begin
        hrdata_ff <= {26'h0, held_ff, ~push_if.ready, ~pop_if.valid,
                      shdn_ff, nap_ff, busy_ff};
      end else if (haddr == scc_pkg::REG_RESULT) begin
        hrdata_ff <= {14'h0, ctrl_ff[scc_pkg::CTRL_FIFO_EN_BIT] ? pop_if.data : result_ff};
      end else if (haddr == scc_pkg::REG_LEVEL) begin
        hrdata_ff <= {27'h0, level};
      end else begin
        hrdata_ff <= '0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  // every transfer is answered okay
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
endmodule

// File: sim/scc_host_model.sv
// host model that shapes the conversion start pin
`timescale 1ns/100ps
module scc_host_model #(
  parameter int unsigned WAKE = 10
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic go,
  input wire logic keep_low,
  output logic conversion_start_n
);
  // ****
  // start pulse shaping
  // ****
  logic [7:0] high_ff;
  logic pend_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conversion_start_n <= 1'b1;
      high_ff <= 8'h00;
      pend_ff <= 1'b0;
    end else begin
      if (!conversion_start_n) begin
        high_ff <= 8'h00;
        conversion_start_n <= ~keep_low;
      end else if (pend_ff && high_ff >= WAKE) begin
        conversion_start_n <= 1'b0;
        pend_ff <= 1'b0;
      end else if (high_ff != 8'hff) begin
        high_ff <= high_ff + 8'h01;
      end
      // a request made at the firing edge stays pending
      if (go) begin
        pend_ff <= 1'b1;
      end
    end
  end
endmodule

// File: sim/scc_core_sva.sv
// checker on the ports of the conversion control block
`timescale 1ns/100ps
module scc_core_sva #(
  parameter int unsigned CONV_CYC = 15,
  parameter int unsigned WAKE_CYC = 10
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic conversion_start_n,
  input wire logic shutdown_request,
  input wire logic reset_pin,
  input wire logic chip_select_n,
  input wire logic [1:0] bus_mode,
  input wire logic [scc_pkg::RESULT_W-1:0] sample_in,
  input wire logic busy,
  input wire logic nap_active,
  input wire logic powered_down,
  input wire logic [scc_pkg::RESULT_W-1:0] data_out,
  input wire logic [scc_pkg::RESULT_W-1:0] data_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // busy length and properties
  // ****
  logic [7:0] busy_len_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_len_ff <= 8'h00;
    end else begin
      busy_len_ff <= busy ? busy_len_ff + 8'h01 : 8'h00;
    end
  end
  property p_start;
    $rose(busy) |-> !$past(conversion_start_n) && $past(conversion_start_n, 2);
  endproperty
  a_start: assert property (p_start) else $error("busy rose without a start edge");
  property p_len;
    $fell(busy) && !$past(reset_pin) |-> busy_len_ff == CONV_CYC;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_result;
    $fell(busy) && !$past(reset_pin) |-> data_out == $past(sample_in);
  endproperty
  a_result: assert property (p_result) else $error("result not on bus");
  property p_float;
    chip_select_n || reset_pin |=> data_oe == '0;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while released");
  property p_drive;
    !chip_select_n && !reset_pin && !shutdown_request && !powered_down &&
      bus_mode == scc_pkg::BUS_MODE_P18 |=> data_oe == '1;
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");
  property p_halt;
    reset_pin |=> !busy;
  endproperty
  a_halt: assert property (p_halt) else $error("conversion not halted");
  property p_shdn;
    powered_down |-> !busy;
  endproperty
  a_shdn: assert property (p_shdn) else $error("busy while shut down");
  property p_pd_cause;
    $rose(powered_down) |-> $past(shutdown_request);
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("shutdown without request");
  property p_nap;
    $fell(busy) && !conversion_start_n && !shutdown_request && !$past(reset_pin)
      |-> ##[0:3] nap_active;
  endproperty
  a_nap: assert property (p_nap) else $error("nap not entered");
  c_done: cover property ($fell(busy));
  c_nap: cover property ($rose(nap_active));
  c_pd: cover property ($rose(powered_down));
endmodule
bind scc_core scc_core_sva #(.CONV_CYC(CONV_CYC), .WAKE_CYC(WAKE_CYC)) scc_core_sva_i (
  .clock(clock), .resetn(resetn), .conversion_start_n(conversion_start_n),
  .shutdown_request(shutdown_request), .reset_pin(reset_pin), .chip_select_n(chip_select_n),
  .bus_mode(bus_mode), .sample_in(sample_in), .busy(busy), .nap_active(nap_active),
  .powered_down(powered_down), .data_out(data_out), .data_oe(data_oe));

// File: sim/scc_core_bench.sv
// self-checking bench of the conversion control block
`timescale 1ns/100ps
`define CHK(nm, g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module scc_core_bench;
  logic clock = 1'b0, resetn = 1'b0, go = 1'b0, keep_low = 1'b0;
  logic shutdown_request = 1'b0, reset_pin = 1'b0, chip_select_n = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0, bus_mode = scc_pkg::BUS_MODE_P18;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [17:0] sample_in = 18'h0, data_out, data_oe, s;
  logic conversion_start_n, busy, nap_active, powered_down, hreadyout, hresp;
  logic [17:0] q[$];
  int fails = 0, checks_done = 0, seed = 11, n;
  always #10 clock = ~clock;
  scc_core scc_core_i (.clock(clock), .resetn(resetn), .conversion_start_n(conversion_start_n),
    .shutdown_request(shutdown_request), .reset_pin(reset_pin), .chip_select_n(chip_select_n),
    .bus_mode(bus_mode), .sample_in(sample_in), .busy(busy), .nap_active(nap_active),
    .powered_down(powered_down), .data_out(data_out), .data_oe(data_oe), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(scc_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  scc_host_model #(.WAKE(scc_pkg::NAP_WAKE_CYCLES)) scc_host_model_i (.clock(clock),
    .resetn(resetn), .go(go), .keep_low(keep_low), .conversion_start_n(conversion_start_n));
  // ****
  // tasks
  // ****
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [17:0] exp_oe(input logic cs, input logic rst);
    return (cs || rst) ? 18'h00000 : 18'h3ffff;
  endfunction
  task automatic hw();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
      if (k > 20) begin
        fails++;
        final_report();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= scc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    hw();
    htrans <= 2'h0;
    hwdata <= d;
    hw();
    rd = hrdata;
    `CHK("hresp", hresp, 1'b0)
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (busy !== v) begin
      @(posedge clock);
      n++;
      if (n > 60) begin
        fails++;
        final_report();
      end
    end
  endtask
  task automatic pulse();
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask
  // go held two edges leaves a second request that lands mid-conversion
  task automatic conv(input logic [17:0] v, input logic sd);
    sample_in <= v;
    go <= 1'b1;
    repeat (2) @(posedge clock);
    go <= 1'b0;
    wt(1'b1);
    // the bus is switched only once the conversion runs
    chip_select_n <= v[0];
    shutdown_request <= sd;
    wt(1'b0);
    `CHK("conv_len", n, scc_pkg::CONV_CYCLES)
    `CHK("result", data_out, v)
    `CHK("bus_oe", data_oe, exp_oe(v[0], 1'b0))
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    ahb(1'b0, scc_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", rd[1:0], scc_pkg::CTRL_RESET_VAL)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", rd, 32'h0)
    conv(18'h2d2d3, 1'b0);
    repeat (6) conv(18'($random(seed)), 1'b0);
    keep_low <= 1'b1;
    conv(18'h0c3c3, 1'b0);
    repeat (3) @(posedge clock);
    `CHK("nap", nap_active, 1'b1)
    keep_low <= 1'b0;
    wt(1'b1);
    `CHK("wake", nap_active, 1'b0)
    wt(1'b0);
    conv(18'h2aaab, 1'b1);
    pulse();
    repeat (30) @(posedge clock);
    `CHK("pd_busy", busy, 1'b0)
    ahb(1'b0, scc_pkg::REG_STATUS, 32'h0);
    `CHK("pd_st", {rd[scc_pkg::ST_HELD_BIT], rd[scc_pkg::ST_SHDN_BIT]}, 2'h3)
    shutdown_request <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("pd_off", powered_down, 1'b0)
    chip_select_n <= 1'b0;
    bus_mode <= scc_pkg::BUS_MODE_P16;
    repeat (2) @(posedge clock);
    `CHK("mode_oe", data_oe, 18'h00000)
    bus_mode <= scc_pkg::BUS_MODE_P18;
    repeat (2) @(posedge clock);
    `CHK("mode_drive", data_oe, exp_oe(1'b0, 1'b0))
    pulse();
    wt(1'b1);
    reset_pin <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("halt", busy, 1'b0)
    `CHK("halt_bus", data_oe, exp_oe(1'b0, 1'b1))
    reset_pin <= 1'b0;
    ahb(1'b1, scc_pkg::REG_CTRL, 32'h2);
    repeat (16) begin
      s = 18'($random(seed));
      q.push_back(s);
      conv(s, 1'b0);
    end
    pulse();
    repeat (30) @(posedge clock);
    `CHK("full_busy", busy, 1'b0)
    ahb(1'b0, scc_pkg::REG_LEVEL, 32'h0);
    `CHK("level", rd, 32'h10)
    while (q.size() > 0) begin
      ahb(1'b0, scc_pkg::REG_RESULT, 32'h0);
      s = q.pop_front();
      `CHK("fifo_word", rd[17:0], s)
      repeat ($random(seed) & 3) @(posedge clock);
    end
    ahb(1'b0, scc_pkg::REG_STATUS, 32'h0);
    `CHK("empty", rd[scc_pkg::ST_EMPTY_BIT], 1'b1)
    final_report();
  end
endmodule
